//--- dv/amel_plc_model.sv
// Purpose: Scanner-side model that raises the clear request and watches faults
// Assumes: The clear request is held for HOLD cycles, then dropped
// Notes: A fault flag seen while the device is in reset is filtered out
`default_nettype none
module amel_plc_model #(
   parameter int unsigned HOLD = 3 // Request length, cycles
) (
   input wire logic core_clk, // Core clock
   input wire logic resetn, // Device reset, low while power is off
   input wire amel_pkg::amel_cyc_t cyc_out, // Cyclic data from device
   input wire logic clr_cmd, // Bench asks for a clear
   output logic error_clear_request, // Clear request bit
   output logic fault_seen // Filtered fault flag
);
   import amel_pkg::*;
   int unsigned cnt_r; // Remaining request cycles
   // Raise the request, then drop it so the clear can complete
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= 0;
      end else if (clr_cmd) begin
         cnt_r <= HOLD;
      end else if (cnt_r != 0) begin
         cnt_r <= cnt_r - 1;
      end
   end
   assign error_clear_request = (cnt_r != 0);
   // Faults during power-down may be spurious
   assign fault_seen = resetn & cyc_out.status[0];
endmodule
`default_nettype wire

//--- dv/tb.sv
// Purpose: Self-checking bench for the alarm monitor and event log
// Assumes: Phase tick every 4 clocks, so one second is 32 clocks
// Notes: Registers are reached through Avalon-MM tasks
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import amel_pkg::*;
   logic core_clk, resetn, wreq, seal, zcal, cal_done, err_set, start_in;
   logic clr_cmd, clr_req, fault_seen, led, relay, aerr, afull;
   logic [9:0] code; // Raised error code
   logic [15:0] temp; // Temperature input
   logic [31:0] rdata, d; // Read data
   logic [3:0] alvl; // Analog level index
   amel_avs_req_t req; // Bus request
   amel_cyc_t cyc; // Cyclic words
   int error_cnt = 0, samples_checked = 0, cyc_cnt = 0, n;

   amel_top #(.TICK_CYC(4)) dut_u (.core_clk(core_clk), .resetn(resetn), .avs_req(req),
      .avs_readdata(rdata), .avs_waitrequest(wreq), .seal_cycle_active(seal),
      .zero_calibration(zcal), .cal_done(cal_done), .err_set(err_set), .err_set_code(code),
      .error_clear_request(clr_req), .start_in(start_in), .actual_temp(temp),
      .cyc_out(cyc), .alarm_led(led), .alarm_relay(relay), .aout_err(aerr),
      .aout_level(alvl), .aout_full(afull));
   amel_plc_model plc_u (.core_clk(core_clk), .resetn(resetn), .cyc_out(cyc),
      .clr_cmd(clr_cmd), .error_clear_request(clr_req), .fault_seen(fault_seen));

   // Clock, 5 ns period
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Cut a hang short
   always @(posedge core_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 40000) begin
         error_cnt++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      req.write <= 1'b1;
      req.address <= a;
      req.writedata <= v;
      do @(posedge core_clk); while (wreq !== 1'b0);
      req.write <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      req.read <= 1'b1;
      req.address <= a;
      do @(posedge core_clk); while (wreq !== 1'b0);
      v = rdata;
      req.read <= 1'b0;
      @(posedge core_clk);
   endtask
   // One-cycle error pulse, returns once the outputs have settled
   task automatic ev(input logic [9:0] c);
      err_set <= 1'b1;
      code <= c;
      @(posedge core_clk);
      err_set <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask
   // Transitions of LED (0) or full-scale flag (1) over one second
   task automatic toggles(input logic s, output int k);
      logic p, c;
      k = 0;
      p = s ? afull : led;
      repeat (32) begin
         @(posedge core_clk);
         c = s ? afull : led;
         if (c !== p) k++;
         p = c;
      end
   endtask
   // Clear through the scanner model; error stays until the bit drops
   task automatic clr();
      clr_cmd <= 1'b1;
      @(posedge core_clk);
      clr_cmd <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(32'(cyc.status[0]), 1);
      do @(posedge core_clk); while (clr_req !== 1'b0);
      repeat (2) @(posedge core_clk);
      chk(32'(cyc.status), 0);
   endtask

   task automatic t_regs();
      rd(REG_CTRL, d); chk(d, 0);
      rd(REG_LOG_CNT, d); chk(d, 0);
      rd(4'hf, d); chk(d, 0);
      wr(4'hf, 32'h5);
      wr(REG_CYCLES, 32'h5);
      rd(REG_CYCLES, d); chk(d, 0);
   endtask
   task automatic t_hours();
      repeat (11560) @(posedge core_clk);
      rd(REG_HOURS, d); chk(d, 1);
   endtask
   task automatic t_cycles();
      repeat (3) begin
         seal <= 1'b1;
         repeat (2) @(posedge core_clk);
         seal <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
      rd(REG_CYCLES, d); chk(d, 3);
   endtask
   task automatic t_log();
      ev(10'd101);
      rd(REG_LOG_CODE, d); chk(d & 32'hfff, 32'h065);
      rd(REG_STATUS, d); chk(32'(d[17]), 0);
      wr(REG_TIME, 32'd100);
      rd(REG_TIME, d); chk(32'(d - 32'd100 < 32'd2), 1);
      rd(REG_STATUS, d); chk(32'(d[17]), 1);
      ev(10'd102);
      rd(REG_LOG_CODE, d); chk(d & 32'hfff, 32'h866);
      rd(REG_LOG_TS, d); chk(32'(d - 32'd100 < 32'd2), 1);
      cal_done <= 1'b1;
      repeat (399) @(posedge core_clk);
      cal_done <= 1'b0;
      @(posedge core_clk);
      rd(REG_LOG_CNT, d); chk(d, 400);
      wr(REG_LOG_SEL, 32'd399);
      rd(REG_LOG_SEL, d); chk(d, 399);
      rd(REG_LOG_CODE, d); chk(d & 32'hfff, 32'h866);
      wr(REG_LOG_SEL, 32'd0);
      rd(REG_LOG_CODE, d); chk((d >> 10) & 32'h3, 3);
      clr();
   endtask
   task automatic t_fault();
      ev(10'd101);
      chk(32'(cyc.status), 1);
      chk(32'(cyc.err_word), 101);
      chk(32'(cyc.temp), 0);
      chk(32'(fault_seen), 1);
      chk({led, relay, aerr, afull, alvl}, 8'he1);
      toggles(0, n); chk(n, 0);
      clr();
      chk(32'(cyc.temp), 32'(temp));
      zcal <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk(32'(cyc.temp), 0);
      zcal <= 1'b0;
   endtask
   task automatic t_warn();
      ev(10'd104);
      chk(32'(cyc.status), 3);
      chk({relay, aerr, alvl}, 6'h18);
      toggles(0, n); chk(n, 8);
      toggles(1, n); chk(n, 2);
      wr(REG_CTRL, 32'h1);
      repeat (2) @(posedge core_clk);
      chk(32'(relay), 1);
      start_in <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk(32'(relay), 0);
      toggles(1, n); chk(n + 32'(afull), 0);
      toggles(0, n); chk(n + 32'(!led), 0);
      wr(REG_CTRL, 32'h0);
      repeat (2) @(posedge core_clk);
      chk(32'(relay), 1);
      start_in <= 1'b0;
      clr();
   endtask
   task automatic t_cfg();
      ev(10'd112);
      toggles(0, n); chk(n, 2);
      chk({cyc.status, 12'h0, alvl}, 32'h0003000a);
      clr();
   endtask
   task automatic t_prio();
      ev(10'd104);
      ev(10'd101);
      chk(32'(cyc.err_word), 101);
      ev(10'd105);
      chk(32'(cyc.err_word), 101);
      clr();
   endtask
   task automatic t_power();
      ev(10'd201);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      chk(32'(cyc.status), 0);
   endtask

   task automatic conclude();
      $display("checks=%0d errors=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence
   initial begin
      resetn = 1'b0;
      req = '0;
      {seal, zcal, cal_done, err_set, start_in, clr_cmd} = '0;
      code = '0;
      temp = 16'hffec;
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      t_regs();
      t_hours();
      t_cycles();
      t_log();
      t_fault();
      t_warn();
      t_cfg();
      t_prio();
      t_power();
      conclude();
   end
endmodule
`default_nettype wire

//--- verilog/amel_pkg.sv
// Purpose: Constants, types and helpers for the alarm monitor and event log
// Assumes: 200 MHz core clock, one clock domain, Avalon-MM register access
// Notes: Summary of operation below, register word indices further down
//
// Summary of operation
// [R1] Count every seal cycle, never clearable; resetn clears the count
// [R2] Count powered time in six-minute steps
// [R3] Log errors and calibrations, keep newest 400; cal_done with err_set logs only the error
// [R4] Stamp each entry with clock date/time
// [R5] Host sets date/time over acyclic services
// [R6] Unset clock: log anyway, timestamps marked invalid
// [R7] LED blinks 4 Hz on calibration-required errors
// [R8] LED blinks 1 Hz on configuration errors
// [R9] LED steady on start-blocking faults
// [R10] Relay off when blinking unless start, on steady
// [R11] Opposite relay polarity inverts every relay state
// [R12] Any error sets fault bit; warnings caution bit
// [R13] Error code in bits 0..9, third word
// [R14] First word: signed temperature, 1 C/count
// [R15] Temperature forced zero during calibration or fault
// [R16] Analog output shows error level during alarm
// [R17] Warnings alternate level/full scale; start holds level
// [R18] Clear error on clear request or power loss
// [R19] Clear completes only when request returns low
// [R20] Host filters errors seen during power-down
// [R21] Start-blocking fault outranks warnings when simultaneous
`default_nettype none
package amel_pkg;
   // Clock and timing
   localparam int unsigned CLK_HZ = 200_000_000; // Core clock rate
   localparam int unsigned BLINK_FAST_HZ = 4; // Fast blink rate
   localparam int unsigned BLINK_SLOW_HZ = 1; // Slow blink and level swap rate
   localparam int unsigned STEP_MIN = 6; // Hours counter resolution, minutes
   // Cycles between phase ticks, two per fast blink period
   localparam int unsigned TICK_CYC_DEF = CLK_HZ / (2 * BLINK_FAST_HZ);
   // Phase ticks per second
   localparam int unsigned TICKS_PER_SEC = 2 * BLINK_FAST_HZ;
   localparam int unsigned SEC_PER_STEP = STEP_MIN * 60; // Seconds per step
   localparam int unsigned SLOW_BIT = 2; // Phase bit toggling at 1 Hz

   // Event log
   localparam int unsigned LOG_DEPTH = 400; // Entries kept
   localparam int unsigned LOG_AW = 9; // Index width
   localparam int unsigned CODE_W = 10; // Error code width

   // Register word indices (byte address is four times)
   localparam logic [3:0] REG_STATUS = 4'h0; // Error state and flags
   localparam logic [3:0] REG_CTRL = 4'h1; // Relay polarity
   localparam logic [3:0] REG_TIME = 4'h2; // Clock, seconds
   localparam logic [3:0] REG_CYCLES = 4'h3; // Seal cycle total
   localparam logic [3:0] REG_HOURS = 4'h4; // Six-minute steps
   localparam logic [3:0] REG_LOG_SEL = 4'h5; // Entry select, 0 is newest
   localparam logic [3:0] REG_LOG_CODE = 4'h6; // Selected entry code and flags
   localparam logic [3:0] REG_LOG_TS = 4'h7; // Selected entry timestamp
   localparam logic [3:0] REG_LOG_CNT = 4'h8; // Entries held

   // Field positions
   localparam int unsigned ST_ACTIVE_BIT = 16; // Status: error pending
   localparam int unsigned ST_CLKOK_BIT = 17; // Status: clock set
   localparam int unsigned LG_CAL_BIT = 10; // Log word: calibration event
   localparam int unsigned LG_TSOK_BIT = 11; // Log word: timestamp valid
   localparam int unsigned CTRL_INV_BIT = 0; // Ctrl: relay inverted
   localparam logic CTRL_INV_RST = 1'b0; // Factory polarity

   // Error classes
   typedef enum logic [1:0] {
      AMEL_CLS_NONE, AMEL_CLS_BLOCK, AMEL_CLS_CAL, AMEL_CLS_CFG
   } amel_cls_t;

   // Avalon request
   typedef struct packed {
      logic read;
      logic write;
      logic [3:0] address;
      logic [31:0] writedata;
   } amel_avs_req_t;

   // Cyclic output data words
   typedef struct packed {
      logic [15:0] temp; // Word 1
      logic [15:0] status; // Word 2, bit 0 fault, bit 1 caution
      logic [15:0] err_word; // Word 3, code in bits 0..9
   } amel_cyc_t;

   // Log entry
   typedef struct packed {
      logic tsok;
      logic cal;
      logic [CODE_W-1:0] code;
      logic [31:0] ts;
   } amel_log_t;

   // Classify an error code
   function automatic amel_cls_t amel_class(input logic [CODE_W-1:0] c);
      amel_class = AMEL_CLS_NONE;
      if ((c >= 10'd101 && c <= 10'd103) || c == 10'd107 || c == 10'd108 ||
          (c >= 10'd201 && c <= 10'd203) || c == 10'd304 || c == 10'd305 ||
          c == 10'd307 || c == 10'd308 || (c >= 10'd900 && c <= 10'd999))
         amel_class = AMEL_CLS_BLOCK;
      else if ((c >= 10'd104 && c <= 10'd106) || c == 10'd211 ||
               c == 10'd302 || c == 10'd303)
         amel_class = AMEL_CLS_CAL;
      else if (c >= 10'd111 && c <= 10'd114)
         amel_class = AMEL_CLS_CFG;
   endfunction

   // Analog output level index, 1..13, for an error code group
   function automatic logic [3:0] amel_level(input logic [CODE_W-1:0] c);
      amel_level = 4'hd;
      if (c == 10'd101) amel_level = 4'h1;
      else if (c == 10'd102) amel_level = 4'h2;
      else if (c == 10'd103 || c == 10'd308) amel_level = 4'h3;
      else if (c == 10'd107 || c == 10'd108 || c == 10'd307) amel_level = 4'h4;
      else if (c >= 10'd201 && c <= 10'd203) amel_level = 4'h5;
      else if (c == 10'd304 || c == 10'd305) amel_level = 4'h6;
      else if (c >= 10'd900) amel_level = 4'h7;
      else if ((c >= 10'd104 && c <= 10'd106) || c == 10'd302 || c == 10'd303)
         amel_level = 4'h8;
      else if (c == 10'd211) amel_level = 4'h9;
      else if (c >= 10'd111 && c <= 10'd114) amel_level = 4'ha;
   endfunction
endpackage
`default_nettype wire

//--- verilog/amel_tick_div.sv
// Purpose: Divider giving a one-cycle enable pulse every N clocks
// Assumes: N of at least 2
// Notes: Pulse is registered
`default_nettype none
module amel_tick_div #(
   parameter int unsigned N = 2
) (
   input wire logic core_clk, // Core clock
   input wire logic resetn, // Async reset, active low
   output logic tick // One-cycle enable
);
   localparam int unsigned CW = $clog2(N);
   localparam logic [CW-1:0] LAST = CW'(N - 1);
   logic [CW-1:0] cnt_r; // Cycle counter
   wire at_last = (cnt_r == LAST); // Wrap point

   // Count and pulse on wrap
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= '0;
         tick <= 1'b0;
      end else begin
         cnt_r <= at_last ? '0 : cnt_r + 1'b1;
         tick <= at_last;
      end
   end
endmodule
`default_nettype wire

//--- verilog/amel_top.sv
// Purpose: Alarm indication, cyclic status, counters and timestamped event log
// Assumes: Error and calibration events arrive as one-cycle pulses
// Notes: Registers reached over Avalon-MM; power interruption is resetn
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`default_nettype none
module amel_top #(
   parameter int unsigned TICK_CYC = amel_pkg::TICK_CYC_DEF // Phase tick period
) (
   input wire logic core_clk, // 200 MHz clock
   input wire logic resetn, // Async reset, active low
   input wire amel_pkg::amel_avs_req_t avs_req, // Avalon request
   output logic [31:0] avs_readdata, // Avalon read data
   output logic avs_waitrequest, // Avalon wait
   input wire logic seal_cycle_active, // Seal cycle bit
   input wire logic zero_calibration, // Calibration running
   input wire logic cal_done, // Calibration executed pulse
   input wire logic err_set, // Error raised pulse
   input wire logic [9:0] err_set_code, // Code of raised error
   input wire logic error_clear_request, // Clear request bit
   input wire logic start_in, // Start input
   input wire logic [15:0] actual_temp, // Signed temperature
   output amel_pkg::amel_cyc_t cyc_out, // Cyclic data words
   output logic alarm_led, // Alarm LED on
   output logic alarm_relay, // Relay energized
   output logic aout_err, // Analog output shows error
   output logic [3:0] aout_level, // Error level index
   output logic aout_full // Analog output at full scale
);
   import amel_pkg::*;

   // Phase ticks and timebase
   logic tick; // Eighth-second pulse
   logic [2:0] ph_r; // Blink phase
   logic [2:0] sub_r; // Ticks within second
   logic [8:0] sec_step_r; // Seconds within six-minute step
   wire sec_tick = tick && (sub_r == 3'(TICKS_PER_SEC - 1)); // Second pulse
   wire step_tick = sec_tick && (sec_step_r == 9'(SEC_PER_STEP - 1)); // Step pulse

   amel_tick_div #(.N(TICK_CYC)) u_div (
      .core_clk(core_clk),
      .resetn(resetn),
      .tick(tick)
   );

   // Blink phase and second count
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ph_r <= '0;
         sub_r <= '0;
      end else if (tick) begin
         ph_r <= ph_r + 3'h1;
         sub_r <= sec_tick ? 3'h0 : sub_r + 3'h1;
      end
   end

   // Counters and clock
   logic [31:0] cycles_r; // Seal cycle total
   logic [31:0] hours_r; // Six-minute steps
   logic [31:0] time_r; // Clock, seconds
   logic clk_ok_r; // Clock has been set
   logic seal_d_r; // Seal bit last cycle
   wire seal_rise = seal_cycle_active && !seal_d_r; // New seal cycle

   // Register decode
   wire wr_time = avs_req.write && avs_req.address == REG_TIME; // Clock set
   wire wr_ctrl = avs_req.write && avs_req.address == REG_CTRL; // Polarity
   wire wr_sel = avs_req.write && avs_req.address == REG_LOG_SEL; // Entry select

   // Seal cycles, only resetn clears it
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         seal_d_r <= 1'b0;
         cycles_r <= '0;
      end else begin
         seal_d_r <= seal_cycle_active;
         if (seal_rise)
            cycles_r <= cycles_r + 32'h1; // R1
      end
   end

   // Total only ever steps up
   a_seal_keep: assert property (@(posedge core_clk) disable iff (!resetn) // R1
      !seal_rise |=> $stable(cycles_r))
      else $error("seal total moved");

   // Powered time in six-minute steps
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sec_step_r <= '0;
         hours_r <= '0;
      end else if (sec_tick) begin
         sec_step_r <= step_tick ? 9'h0 : sec_step_r + 9'h1; // R2
         if (step_tick)
            hours_r <= hours_r + 32'h1; // R2
      end
   end

   // Hours total only ever steps up
   a_hours_keep: assert property (@(posedge core_clk) disable iff (!resetn) // R2
      !step_tick |=> $stable(hours_r))
      else $error("hours total moved");

   // Built-in clock, set by host write
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         time_r <= '0;
         clk_ok_r <= 1'b0;
      end else if (wr_time) begin
         time_r <= avs_req.writedata; // R5
         clk_ok_r <= 1'b1; // R5
      end else if (sec_tick) begin
         time_r <= time_r + 32'h1;
      end
   end

   // Clock stays marked set once written
   a_clock_keep: assert property (@(posedge core_clk) disable iff (!resetn) // R6
      clk_ok_r |=> clk_ok_r)
      else $error("clock flag dropped");

   // Error state
   logic err_act_r; // Error pending
   logic [9:0] err_code_r; // Reported code
   logic clr_arm_r; // Clear request seen
   amel_cls_t cls_cur; // Class of reported code
   amel_cls_t cls_new; // Class of incoming code
   assign cls_cur = err_act_r ? amel_class(err_code_r) : AMEL_CLS_NONE;
   assign cls_new = amel_class(err_set_code);
   wire clr_done = clr_arm_r && !error_clear_request; // R19
   // Take new code if idle, if a clear completes now, or if it outranks a warning
   wire err_take = err_set && (!err_act_r || clr_done ||
      (cls_new == AMEL_CLS_BLOCK && cls_cur != AMEL_CLS_BLOCK)); // R21

   // Raise, replace and clear error; raise wins over clear
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         err_act_r <= 1'b0; // R18
         err_code_r <= '0;
         clr_arm_r <= 1'b0;
      end else begin
         if (error_clear_request)
            clr_arm_r <= 1'b1; // R18
         else if (clr_done)
            clr_arm_r <= 1'b0;
         if (err_take) begin
            err_act_r <= 1'b1;
            err_code_r <= err_set_code;
         end else if (clr_done && err_act_r) begin
            err_act_r <= 1'b0; // R19
            err_code_r <= '0;
         end
      end
   end

   // Clear completes when the request drops
   a_clear_done: assert property (@(posedge core_clk) disable iff (!resetn) // R18
      clr_done && !err_set |=> !err_act_r)
      else $error("clear not completed");

   // Warning and blink decode
   wire is_block = cls_cur == AMEL_CLS_BLOCK; // Steady fault
   wire is_cal = cls_cur == AMEL_CLS_CAL; // Calibration warning
   wire is_cfg = cls_cur == AMEL_CLS_CFG; // Configuration warning
   wire is_warn = is_cal || is_cfg; // Either warning
   wire fast_on = !ph_r[0]; // 4 Hz square
   wire slow_on = !ph_r[SLOW_BIT]; // 1 Hz square
   wire led_nxt = is_block || (is_warn && start_in) || // R9
      (is_cal && fast_on) || // R7
      (is_cfg && slow_on); // R8
   wire relay_def = is_block || (is_warn && start_in); // R10
   logic relay_inv_r; // Relay polarity inverted
   wire relay_nxt = relay_def ^ relay_inv_r; // R11
   wire temp_zero = zero_calibration || err_act_r; // R15

   // Polarity control
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         relay_inv_r <= CTRL_INV_RST;
      else if (wr_ctrl)
         relay_inv_r <= avs_req.writedata[CTRL_INV_BIT];
   end

   // Priority, blink patterns and relay while warning
   a_block_wins: assert property (@(posedge core_clk) disable iff (!resetn) // R21
      err_set && cls_new == AMEL_CLS_BLOCK |=> is_block)
      else $error("blocking fault not shown");
   a_fast_blink: assert property (@(posedge core_clk) disable iff (!resetn) // R7
      is_cal && !start_in |=> alarm_led == !$past(ph_r[0]))
      else $error("fast blink wrong");
   a_slow_blink: assert property (@(posedge core_clk) disable iff (!resetn) // R8
      is_cfg && !start_in |=> alarm_led == !$past(ph_r[SLOW_BIT]))
      else $error("slow blink wrong");
   a_relay_open: assert property (@(posedge core_clk) disable iff (!resetn) // R10
      is_warn && !start_in && !relay_inv_r |=> !alarm_relay)
      else $error("relay on while blinking");

   // Indicator outputs from flip-flops
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         alarm_led <= 1'b0;
         alarm_relay <= CTRL_INV_RST;
         aout_err <= 1'b0;
         aout_level <= '0;
         aout_full <= 1'b0;
      end else begin
         alarm_led <= led_nxt;
         alarm_relay <= relay_nxt;
         aout_err <= err_act_r; // R16
         aout_level <= err_act_r ? amel_level(err_code_r) : 4'h0; // R16
         aout_full <= is_warn && !start_in && !slow_on; // R17
      end
   end

   // Analog error level
   a_level_out: assert property (@(posedge core_clk) disable iff (!resetn) // R16
      err_act_r |=> aout_err && aout_level != 4'h0)
      else $error("error level missing");
   a_level_hold: assert property (@(posedge core_clk) disable iff (!resetn) // R17
      start_in |=> !aout_full)
      else $error("full scale with start");

   // Cyclic words
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         cyc_out <= '0;
      else begin
         cyc_out.temp <= temp_zero ? 16'h0 : actual_temp; // R14 R15
         cyc_out.status <= {14'h0, is_warn, err_act_r}; // R12
         cyc_out.err_word <= {6'h0, err_code_r}; // R13
      end
   end

   // Status bits and temperature word
   a_caution_bit: assert property (@(posedge core_clk) disable iff (!resetn) // R12
      is_warn |=> cyc_out.status[1])
      else $error("caution bit missing");
   a_temp_pass: assert property (@(posedge core_clk) disable iff (!resetn) // R14
      !temp_zero |=> cyc_out.temp == $past(actual_temp))
      else $error("temperature not passed");

   // Event log
   amel_log_t log_mem_r [LOG_DEPTH]; // Entry storage
   logic [LOG_AW-1:0] wr_ptr_r; // Next slot
   logic [LOG_AW-1:0] log_cnt_r; // Entries held
   logic [LOG_AW-1:0] sel_r; // Read select, 0 newest
   wire log_we = err_set || cal_done; // R3
   amel_log_t log_new; // Entry being written
   assign log_new = '{tsok: clk_ok_r, cal: !err_set, // R6
      code: err_set ? err_set_code : 10'h0, ts: time_r}; // R4
   wire [LOG_AW:0] rd_sum = {1'b0, wr_ptr_r} + 10'(LOG_DEPTH - 1) - {1'b0, sel_r};
   wire [LOG_AW-1:0] rd_idx = (rd_sum >= 10'(LOG_DEPTH)) ?
      9'(rd_sum - 10'(LOG_DEPTH)) : rd_sum[LOG_AW-1:0];
   amel_log_t log_rd; // Selected entry
   assign log_rd = (sel_r < log_cnt_r) ? log_mem_r[rd_idx] : '0;
   wire [LOG_AW-1:0] ptr_inc = (wr_ptr_r == 9'(LOG_DEPTH - 1)) ? 9'h0 : wr_ptr_r + 9'h1;

   // Log storage, oldest overwritten when full
   always_ff @(posedge core_clk) begin
      if (log_we)
         log_mem_r[wr_ptr_r] <= log_new; // R3 R4
   end

   // Log pointers and select
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_r <= '0;
         log_cnt_r <= '0;
         sel_r <= '0;
      end else begin
         if (log_we) begin
            wr_ptr_r <= ptr_inc; // R3
            if (log_cnt_r != 9'(LOG_DEPTH))
               log_cnt_r <= log_cnt_r + 9'h1; // R3
         end
         if (wr_sel)
            sel_r <= avs_req.writedata[LOG_AW-1:0];
      end
   end

   // Avalon read path, one wait state
   logic rd_ack_r; // Read answered this edge
   logic [31:0] rd_mux; // Read data select
   always_comb begin
      rd_mux = 32'h0;
      case (avs_req.address)
         REG_STATUS: rd_mux = {14'h0, clk_ok_r, err_act_r, 6'h0, err_code_r};
         REG_CTRL: rd_mux = {31'h0, relay_inv_r};
         REG_TIME: rd_mux = time_r;
         REG_CYCLES: rd_mux = cycles_r;
         REG_HOURS: rd_mux = hours_r;
         REG_LOG_SEL: rd_mux = {23'h0, sel_r};
         REG_LOG_CODE: rd_mux = {20'h0, log_rd.tsok, log_rd.cal, log_rd.code};
         REG_LOG_TS: rd_mux = log_rd.ts;
         REG_LOG_CNT: rd_mux = {23'h0, log_cnt_r};
         default: rd_mux = 32'h0;
      endcase
   end
   assign avs_waitrequest = avs_req.read && !rd_ack_r;

   // Capture read data during the wait cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rd_ack_r <= 1'b0;
         avs_readdata <= '0;
      end else begin
         rd_ack_r <= avs_req.read && !rd_ack_r;
         if (avs_req.read && !rd_ack_r)
            avs_readdata <= rd_mux;
      end
   end

   // Checks
   a_seal_count: assert property (@(posedge core_clk) disable iff (!resetn) // R1
      seal_rise |=> cycles_r == $past(cycles_r) + 32'h1)
      else $error("seal cycle not counted");
   a_hours_step: assert property (@(posedge core_clk) disable iff (!resetn) // R2
      step_tick |=> hours_r == $past(hours_r) + 32'h1)
      else $error("hours step missed");
   a_log_bound: assert property (@(posedge core_clk) disable iff (!resetn) // R3
      log_cnt_r <= 9'(LOG_DEPTH))
      else $error("log count above depth");
   a_clock_set: assert property (@(posedge core_clk) disable iff (!resetn) // R5
      wr_time |=> clk_ok_r && time_r == $past(avs_req.writedata))
      else $error("clock write lost");
   a_steady_led: assert property (@(posedge core_clk) disable iff (!resetn) // R9
      is_block ##1 is_block |-> alarm_led)
      else $error("steady fault LED off");
   a_relay_state: assert property (@(posedge core_clk) disable iff (!resetn) // R11
      $stable(err_code_r) && $stable(start_in) && $stable(relay_inv_r)
      |-> alarm_relay == (relay_def ^ relay_inv_r))
      else $error("relay state wrong");
   a_temp_zero: assert property (@(posedge core_clk) disable iff (!resetn) // R15
      temp_zero |=> cyc_out.temp == 16'h0)
      else $error("temperature not forced");
   a_code_word: assert property (@(posedge core_clk) disable iff (!resetn) // R13
      err_act_r |=> cyc_out.err_word[9:0] == $past(err_code_r)
      && cyc_out.status[0])
      else $error("code word mismatch");
   a_clear_hold: assert property (@(posedge core_clk) disable iff (!resetn) // R19
      err_act_r && error_clear_request |=> err_act_r)
      else $error("cleared while request high");
endmodule
`default_nettype wire
